/* bench/ulpi_link_model.sv */
// link controller model issuing immediate register reads and writes
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/100ps
`include "ulpi_vendor_map.svh"
module ulpi_link_model (
  // clock and answer
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  // requests
  output logic            wr_o,
  output logic            rd_o,
  output logic      [5:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 6'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #5;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = (a == `VND_ID_CONV || a == `VND_ID_CONV_SET) ? (d & 8'hDF) : d;
    @(posedge clk_i);
    #5;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~wdata_o;
  endtask
  // a missing answer comes back as unknown
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #5;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #5;
    rd_o = 1'b0;
    addr_o = ~a;
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask
endmodule

/* bench/ulpi_vendor_register_bank_chk.sv */
// assertions on the vendor register bank ports
// assumes binding into every bank instance
`timescale 1ns/100ps
module ulpi_vendor_register_bank_chk #(
  parameter int ID_MEASURE_CYCLES = 5640
) (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic       carkit_irq_enable_i,
  input wire logic       serial_mode_i,
  input wire logic       id_measure_run_o,
  input wire logic       id_measure_done_o,
  input wire logic       alt_int_o,
  input wire logic       headset_mode_en_o,
  input wire logic       charger_pullup_pos_o,
  input wire logic       charger_pullup_neg_o
);
  localparam int LO = ID_MEASURE_CYCLES - 2;
  localparam int HI = ID_MEASURE_CYCLES + 2;
  logic        run_q_r;
  logic [15:0] len_r;
  // run length is kept after the run ends so the done edge can be judged
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q_r <= 1'b0;
      len_r   <= 16'h0000;
    end else begin
      run_q_r <= id_measure_run_o;
      if (id_measure_run_o) begin
        len_r <= run_q_r ? len_r + 16'h0001 : 16'h0001;
      end
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence go_write;
    reg_wr_i && (reg_addr_i == 6'h36 || reg_addr_i == 6'h37) && reg_wdata_i[4];
  endsequence
  sequence hs_quiet;
    !(reg_wr_i && reg_addr_i == 6'h33);
  endsequence
  a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rdata_held: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved");
  a_go_starts: assert property (go_write ##1 !reg_wr_i |-> ##[1:3] id_measure_run_o)
    else $error("no conversion start");
  a_run_length: assert property ($rose(id_measure_done_o) |-> len_r >= LO && len_r <= HI)
    else $error("conversion length wrong");
  a_alt_on_done: assert property ($rose(id_measure_done_o) && carkit_irq_enable_i |-> ##[0:1] alt_int_o)
    else $error("no alternate interrupt");
  a_alt_pulse: assert property (alt_int_o |=> !alt_int_o)
    else $error("interrupt not a pulse");
  a_headset_on: assert property ((reg_wr_i && reg_addr_i == 6'h33 && reg_wdata_i[3:0] == 4'hA)
    ##1 hs_quiet |-> ##1 headset_mode_en_o)
    else $error("headset mode off");
  a_headset_off: assert property ((reg_wr_i && reg_addr_i == 6'h33 && reg_wdata_i[3:0] != 4'hA)
    ##1 hs_quiet |-> ##1 !headset_mode_en_o)
    else $error("headset mode on");
  a_pullup_forced: assert property (serial_mode_i |=> charger_pullup_pos_o && charger_pullup_neg_o)
    else $error("pull-ups not forced");
endmodule

bind ulpi_vendor_register_bank ulpi_vendor_register_bank_chk #(
  .ID_MEASURE_CYCLES(ID_MEASURE_CYCLES)
) chk_u (.*);

/* bench/ulpi_vendor_register_bank_tb_top.sv */
// self-checking bench for the vendor register bank
// assumes link_u makes every register access
`timescale 1ns/100ps
module ulpi_vendor_register_bank_tb_top;
  localparam int P = 20;
  logic       ref_clk_i;
  logic       rst_n_i;
  logic       wr, rd, rv, ck_en, ser, txen, hs, run, done, alt, swp, pp, pn;
  logic [5:0] addr;
  logic [7:0] wd, rdat, d, pins;
  logic [2:0] code, res;
  logic [1:0] amp, ldo;
  int         n_errors, comparisons;

  assign pins = {ldo, pn, pp, swp, hs, amp};
  ulpi_vendor_register_bank #(.ID_MEASURE_CYCLES(P)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .carkit_irq_enable_i(ck_en), .serial_mode_i(ser), .serial_transmit_enable_i(txen),
    .id_resistor_code_i(code), .hs_tx_amplitude_o(amp), .headset_mode_en_o(hs),
    .id_measure_run_o(run), .id_resistor_result_o(res), .id_measure_done_o(done),
    .alt_int_o(alt), .data_line_swap_o(swp), .charger_pullup_pos_o(pp),
    .charger_pullup_neg_o(pn), .ldo_level_o(ldo));
  ulpi_link_model link_u (.clk_i(ref_clk_i), .rdata_i(rdat), .rvalid_i(rv),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    link_u.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask

  // pins are registered behind the register, so two edges pass first
  task automatic pchk(input logic [7:0] e);
    repeat (2) @(posedge ref_clk_i);
    #5;
    chk("pins", e, pins);
  endtask

  task automatic conv(input logic [2:0] c, input logic ea, input logic [5:0] a,
                      input logic [7:0] e);
    int   n;
    logic seen;
    seen = 1'b0;
    code = c;
    link_u.wr(6'h37, 8'h10);
    for (n = 0; n < 4 * P && done !== 1'b1; n++) begin
      @(posedge ref_clk_i);
      #5;
      seen = seen | (alt === 1'b1);
    end
    chk("done time", 8'h01, 8'(n >= P - 2 && n <= P + 4));
    chk("result", {5'h00, c}, {5'h00, res});
    @(posedge ref_clk_i);
    #5;
    seen = seen | (alt === 1'b1);
    chk("alt", {7'h00, ea}, {7'h00, seen});
    rchk(a, e);
  endtask

  initial begin
    n_errors = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    ck_en = 1'b0;
    ser = 1'b0;
    txen = 1'b0;
    code = 3'h0;
    repeat (20) @(posedge ref_clk_i);
    #5;
    rst_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rchk(6'h31, 8'h00);
    rchk(6'h33, 8'h00);
    rchk(6'h36, 8'h00);
    rchk(6'h39, 8'h04);
    rchk(6'h30, 8'h00);
    for (int i = 0; i < 4; i++) begin
      link_u.wr(6'h31, {1'b1, 2'(i), 5'h1F});
      rchk(6'h31, {1'b0, 2'(i), 5'h00});
      pchk({6'h00, 2'(i)});
    end
    link_u.wr(6'h33, 8'hFA);
    rchk(6'h33, 8'h0A);
    pchk(8'h07);
    link_u.wr(6'h33, 8'h0B);
    pchk(8'h03);
    link_u.wr(6'h39, 8'h87);
    rchk(6'h3A, 8'h86);
    pchk(8'h8B);
    link_u.wr(6'h3A, 8'h30);
    rchk(6'h3B, 8'hB6);
    pchk(8'hBB);
    link_u.wr(6'h3B, 8'h10);
    rchk(6'h39, 8'hA6);
    pchk(8'hAB);
    ser = 1'b1;
    pchk(8'hBB);
    txen = 1'b1;
    pchk(8'h7B);
    ser = 1'b0;
    txen = 1'b0;
    pchk(8'hAB);
    link_u.wr(6'h3B, 8'hFF);
    rchk(6'h39, 8'h00);
    conv(3'h5, 1'b0, 6'h38, 8'h0D);
    rchk(6'h36, 8'h05);
    link_u.wr(6'h37, 8'h40);
    conv(3'h7, 1'b1, 6'h37, 8'h4F);
    link_u.wr(6'h38, 8'h40);
    ck_en = 1'b1;
    conv(3'h2, 1'b1, 6'h36, 8'h0A);
    ck_en = 1'b0;
    link_u.wr(6'h37, 8'h10);
    link_u.wr(6'h38, 8'h10);
    repeat (P + 5) @(posedge ref_clk_i);
    #5;
    chk("abort done", 8'h00, {7'h00, done});
    link_u.wr(6'h36, 8'hA7);
    rchk(6'h36, 8'h07);
    // a second reset after the aborted run must bring back the reset values and idle pins
    rst_n_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #5;
    rst_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rchk(6'h39, 8'h04);
    rchk(6'h31, 8'h00);
    pchk(8'h00);
    print_verdict();
  end
endmodule

/* logic/id_measure_timer.sv */
// times one id resistor conversion and samples the converter code at its end
// assumes the analog converter presents a settled code while run_o is high
`timescale 1ns/100ps
`include "ulpi_vendor_map.svh"
module id_measure_timer #(
  parameter int MEASURE_CYCLES = 5640
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       go_i,
  input  wire logic [2:0] code_i,
  // status
  output logic            run_o,
  output logic            done_o,
  output logic      [2:0] result_o
);

  ulpi_vendor_pkg::meas_state_type state_r;
  logic [`ID_MEASURE_CNT_W-1:0]    cnt_r;
  logic                            done_r;
  logic [2:0]                      result_r;
  logic                            go_d_r;
  logic                            finish;

  assign finish = (state_r == ulpi_vendor_pkg::MEAS_RUN) &&
                  (cnt_r == `ID_MEASURE_CNT_W'(MEASURE_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      go_d_r <= 1'b0;
    end else begin
      go_d_r <= go_i;
    end
  end

  // a go bit dropped by software aborts the conversion quietly
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ulpi_vendor_pkg::MEAS_IDLE;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        ulpi_vendor_pkg::MEAS_IDLE: begin
          cnt_r <= '0;
          if (go_i && !go_d_r) begin
            state_r <= ulpi_vendor_pkg::MEAS_RUN; // see R8
          end
        end
        ulpi_vendor_pkg::MEAS_RUN: begin
          cnt_r <= cnt_r + 1'b1; // see R6
          if (finish || !go_i) begin
            state_r <= ulpi_vendor_pkg::MEAS_IDLE;
          end
        end
        default: begin
          state_r <= ulpi_vendor_pkg::MEAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_r   <= 1'b0;
      result_r <= 3'h0;
    end else begin
      done_r <= finish && go_i; // see R6
      if (finish && go_i) begin
        result_r <= code_i; // see R5
      end
    end
  end

  assign run_o    = (state_r == ulpi_vendor_pkg::MEAS_RUN);
  assign done_o   = done_r;
  assign result_o = result_r;

endmodule

/* logic/ulpi_vendor_map.svh */
// register map, field positions, reset values and timing of the vendor register bank
// assumes a 6-bit immediate register address and 8-bit register data
//
// Contract
// R1: amplitude field picks high-speed drive level
// R2: headset mode only with key 1010
// R3: id register: read all, write/set/clear
// R4: io register: read all, write/set/clear
// R5: three-bit result encodes measured id resistance
// R6: done flag self-sets after 282 us conversion
// R7: vendor read clears done; carkit read not
// R8: go bit starts conversion, self-clears after
// R9: link keeps id register bit 5 zero
// R10: done with enable raises alternate interrupt
// R11: interrupt enable ORs vendor and carkit bits
// R12: swap bit exchanges data pins, also serial
// R13: serial ldo level, default 01, on txd
// R14: charger pull-up bits drive each pin
// R15: serial mode forces both pull-ups on
// R16: usb ldo level default 00 otherwise
// R17: bank 30h-3Fh uses immediate register access
// R18: set/clear addresses touch only one bits
// R19: reserved read-only bits read zero
`ifndef ULPI_VENDOR_MAP_SVH
`define ULPI_VENDOR_MAP_SVH

`define VND_ADDR_W           6
`define VND_DATA_W           8
`define VND_BANK_LO          6'h30
`define VND_BANK_HI          6'h3F

`define VND_HS_TX_AMP        6'h31
`define VND_HEADSET          6'h33
`define VND_ID_CONV          6'h36
`define VND_ID_CONV_SET      6'h37
`define VND_ID_CONV_CLR      6'h38
`define VND_IO_PWR           6'h39
`define VND_IO_PWR_SET       6'h3A
`define VND_IO_PWR_CLR       6'h3B

`define VND_HS_TX_AMP_MASK   8'h60
`define VND_HEADSET_MASK     8'h0F
`define VND_ID_CONV_WMASK    8'h77
`define VND_ID_CONV_RMASK    8'h7F
`define VND_IO_PWR_MASK      8'hFE

`define VND_HS_TX_AMP_RST    8'h00
`define VND_HEADSET_RST      8'h00
`define VND_ID_CONV_RST      8'h00
`define VND_IO_PWR_RST       8'h04

`define AMP_LSB              5
`define AMP_MSB              6
`define HEADSET_KEY          4'hA
`define ID_RESULT_MSB        2
`define ID_DONE_BIT          3
`define ID_GO_BIT            4
`define ID_IRQ_EN_BIT        6
`define IO_SWAP_BIT          1
`define IO_SER_LDO_LSB       2
`define IO_SER_LDO_MSB       3
`define IO_PULL_POS_BIT      4
`define IO_PULL_NEG_BIT      5
`define IO_USB_LDO_LSB       6
`define IO_USB_LDO_MSB       7

`define ID_MEASURE_TIME_NS   282000
`define REF_CLK_PERIOD_NS    50
`define ID_MEASURE_CNT_W     13

`endif

/* logic/ulpi_vendor_pkg.sv */
// types shared by the vendor register bank
// assumes nothing beyond a SystemVerilog compiler
package ulpi_vendor_pkg;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b01,
    MEAS_RUN  = 2'b10
  } meas_state_type;

endpackage

/* logic/ulpi_vendor_register_bank.sv */
// vendor register bank reached by immediate register reads and writes in 30h..3Fh
// assumes the ulpi framing logic turns register commands into one-cycle strobes
`timescale 1ns/100ps
`include "ulpi_vendor_map.svh"
module ulpi_vendor_register_bank #(
  parameter int ID_MEASURE_CYCLES =
    (`ID_MEASURE_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // register access from the ulpi command decoder
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire logic [`VND_ADDR_W-1:0] reg_addr_i,
  input  wire logic [`VND_DATA_W-1:0] reg_wdata_i,
  output logic      [`VND_DATA_W-1:0] reg_rdata_o,
  output logic                        reg_rvalid_o,
  // neighbouring blocks
  input  wire logic                   carkit_irq_enable_i,
  input  wire logic                   serial_mode_i,
  input  wire logic                   serial_transmit_enable_i,
  input  wire logic [2:0]             id_resistor_code_i,
  // analog and rxcmd controls
  output logic      [1:0]             hs_tx_amplitude_o,
  output logic                        headset_mode_en_o,
  output logic                        id_measure_run_o,
  output logic      [2:0]             id_resistor_result_o,
  output logic                        id_measure_done_o,
  output logic                        alt_int_o,
  output logic                        data_line_swap_o,
  output logic                        charger_pullup_pos_o,
  output logic                        charger_pullup_neg_o,
  output logic      [1:0]             ldo_level_o
);

  // reset release
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // address decode, every register sits on the immediate map
  logic in_bank;
  logic wr_amp;
  logic wr_headset;
  logic wr_id;
  logic set_id;
  logic clr_id;
  logic wr_io;
  logic set_io;
  logic clr_io;
  logic rd_id;

  assign in_bank    = (reg_addr_i >= `VND_BANK_LO) && (reg_addr_i <= `VND_BANK_HI); // see R17
  assign wr_amp     = reg_wr_i && in_bank && (reg_addr_i == `VND_HS_TX_AMP);
  assign wr_headset = reg_wr_i && in_bank && (reg_addr_i == `VND_HEADSET);
  assign wr_id      = reg_wr_i && (reg_addr_i == `VND_ID_CONV);     // see R3
  assign set_id     = reg_wr_i && (reg_addr_i == `VND_ID_CONV_SET); // see R3
  assign clr_id     = reg_wr_i && (reg_addr_i == `VND_ID_CONV_CLR); // see R3
  assign wr_io      = reg_wr_i && (reg_addr_i == `VND_IO_PWR);      // see R4
  assign set_io     = reg_wr_i && (reg_addr_i == `VND_IO_PWR_SET);  // see R4
  assign clr_io     = reg_wr_i && (reg_addr_i == `VND_IO_PWR_CLR);  // see R4
  assign rd_id      = reg_rd_i && (reg_addr_i >= `VND_ID_CONV) && (reg_addr_i <= `VND_ID_CONV_CLR);

  // plain read/write registers, reserved bits never stored
  logic [7:0] amp_r;
  logic [7:0] headset_r;

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      amp_r <= `VND_HS_TX_AMP_RST;
    end else if (wr_amp) begin
      amp_r <= reg_wdata_i & `VND_HS_TX_AMP_MASK; // see R19
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      headset_r <= `VND_HEADSET_RST;
    end else if (wr_headset) begin
      headset_r <= reg_wdata_i & `VND_HEADSET_MASK; // see R19
    end
  end

  // id resistor conversion register
  logic [7:0] id_q;
  logic [7:0] id_hw_clr;
  logic [7:0] id_hw_set;
  logic [7:0] id_load_mask;
  logic [7:0] id_load_val;
  logic       meas_run;
  logic       meas_done;
  logic [2:0] meas_result;

  // done has no software write path; only a vendor read clears it
  always_comb begin
    id_hw_clr = 8'h00;
    id_hw_set = 8'h00;
    id_hw_clr[`ID_DONE_BIT] = rd_id; // see R7
    id_hw_clr[`ID_GO_BIT]   = meas_done; // see R8
    id_hw_set[`ID_DONE_BIT] = meas_done; // see R6
    id_load_mask = 8'h00;
    id_load_val  = 8'h00;
    if (meas_done) begin
      id_load_mask[`ID_RESULT_MSB:0] = 3'h7;
      id_load_val[`ID_RESULT_MSB:0]  = meas_result; // see R5
    end
  end

  // bit 5 is stored as written; the link is expected to leave it at zero (see R9)
  wsc_reg #(
    .RESET_VAL (`VND_ID_CONV_RST),
    .WMASK     (`VND_ID_CONV_WMASK)
  ) u_id_reg (
    .clk_i          (ref_clk_i),
    .rst_n_i        (rst_sync_r),
    .wr_i           (wr_id),
    .set_i          (set_id),
    .clr_i          (clr_id),
    .wdata_i        (reg_wdata_i),
    .hw_clr_i       (id_hw_clr),
    .hw_set_i       (id_hw_set),
    .hw_load_mask_i (id_load_mask),
    .hw_load_val_i  (id_load_val),
    .q_o            (id_q)
  );

  id_measure_timer #(
    .MEASURE_CYCLES (ID_MEASURE_CYCLES)
  ) u_timer (
    .clk_i    (ref_clk_i),
    .rst_n_i  (rst_sync_r),
    .go_i     (id_q[`ID_GO_BIT]), // see R8
    .code_i   (id_resistor_code_i),
    .run_o    (meas_run),
    .done_o   (meas_done),
    .result_o (meas_result)
  );

  // usb io and power management register
  logic [7:0] io_q;

  wsc_reg #(
    .RESET_VAL (`VND_IO_PWR_RST),
    .WMASK     (`VND_IO_PWR_MASK)
  ) u_io_reg (
    .clk_i          (ref_clk_i),
    .rst_n_i        (rst_sync_r),
    .wr_i           (wr_io),
    .set_i          (set_io),
    .clr_i          (clr_io),
    .wdata_i        (reg_wdata_i),
    .hw_clr_i       (8'h00),
    .hw_set_i       (8'h00),
    .hw_load_mask_i (8'h00),
    .hw_load_val_i  (8'h00),
    .q_o            (io_q)
  );

  // read data returned one cycle after the strobe; unmapped addresses read zero
  logic [7:0] rdata_nxt;

  always_comb begin
    case (reg_addr_i)
      `VND_HS_TX_AMP:   rdata_nxt = amp_r & `VND_HS_TX_AMP_MASK; // see R19
      `VND_HEADSET:     rdata_nxt = headset_r & `VND_HEADSET_MASK;
      `VND_ID_CONV,
      `VND_ID_CONV_SET,
      `VND_ID_CONV_CLR: rdata_nxt = id_q & `VND_ID_CONV_RMASK; // see R3
      `VND_IO_PWR,
      `VND_IO_PWR_SET,
      `VND_IO_PWR_CLR:  rdata_nxt = io_q & `VND_IO_PWR_MASK; // see R4
      default:          rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_nxt;
      end
    end
  end

  // transmit amplitude and headset key
  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      hs_tx_amplitude_o <= 2'h0;
      headset_mode_en_o <= 1'b0;
    end else begin
      hs_tx_amplitude_o <= amp_r[`AMP_MSB:`AMP_LSB]; // see R1
      headset_mode_en_o <= (headset_r == 8'(`HEADSET_KEY)); // see R2
    end
  end

  // conversion status towards the rxcmd builder
  logic done_seen_r;
  logic irq_enable;

  assign irq_enable = id_q[`ID_IRQ_EN_BIT] | carkit_irq_enable_i; // see R11

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      done_seen_r          <= 1'b0;
      alt_int_o            <= 1'b0;
      id_measure_run_o     <= 1'b0;
      id_measure_done_o    <= 1'b0;
      id_resistor_result_o <= 3'h0;
    end else begin
      done_seen_r          <= id_q[`ID_DONE_BIT];
      alt_int_o            <= id_q[`ID_DONE_BIT] && !done_seen_r && irq_enable; // see R10
      id_measure_run_o     <= meas_run;
      id_measure_done_o    <= id_q[`ID_DONE_BIT];
      id_resistor_result_o <= id_q[`ID_RESULT_MSB:0]; // see R5
    end
  end

  // pin routing and regulator level
  logic serial_active;

  assign serial_active = serial_mode_i && serial_transmit_enable_i;

  always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      data_line_swap_o     <= 1'b0;
      charger_pullup_pos_o <= 1'b0;
      charger_pullup_neg_o <= 1'b0;
      ldo_level_o          <= 2'h0;
    end else begin
      // one swap bit covers usb and serial routing alike
      data_line_swap_o     <= io_q[`IO_SWAP_BIT]; // see R12
      charger_pullup_pos_o <= io_q[`IO_PULL_POS_BIT] | serial_mode_i; // see R14, see R15
      charger_pullup_neg_o <= io_q[`IO_PULL_NEG_BIT] | serial_mode_i; // see R14, see R15
      if (serial_active) begin
        ldo_level_o <= io_q[`IO_SER_LDO_MSB:`IO_SER_LDO_LSB]; // see R13
      end else begin
        ldo_level_o <= io_q[`IO_USB_LDO_MSB:`IO_USB_LDO_LSB]; // see R16
      end
    end
  end

endmodule

/* logic/wsc_reg.sv */
// one 8-bit register with plain write, bit-set and bit-clear strobes and a hardware load path
// assumes one strobe per cycle from the decoder and active-low reset already synchronised
`timescale 1ns/100ps
module wsc_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hFF
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // software side
  input  wire logic       wr_i,
  input  wire logic       set_i,
  input  wire logic       clr_i,
  input  wire logic [7:0] wdata_i,
  // hardware side, applied after software so hardware wins
  input  wire logic [7:0] hw_clr_i,
  input  wire logic [7:0] hw_set_i,
  input  wire logic [7:0] hw_load_mask_i,
  input  wire logic [7:0] hw_load_val_i,
  // contents
  output logic      [7:0] q_o
);

  logic [7:0] q_r;
  logic [7:0] sw_nxt;
  logic [7:0] q_nxt;

  always_comb begin
    sw_nxt = q_r;
    if (wr_i) begin
      sw_nxt = (q_r & ~WMASK) | (wdata_i & WMASK);
    end else if (set_i) begin
      sw_nxt = q_r | (wdata_i & WMASK); // see R18
    end else if (clr_i) begin
      sw_nxt = q_r & ~(wdata_i & WMASK); // see R18
    end
    // event set beats any clear in the same cycle
    q_nxt = (((sw_nxt & ~hw_clr_i) & ~hw_load_mask_i) | (hw_load_val_i & hw_load_mask_i))
            | hw_set_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= RESET_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule
